// file: core/bmbp_pkg.sv
package bmbp_pkg;

   // ------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [5:0] BMBP_IDX_UPPER_DATA = 6'h00;
   localparam logic [5:0] BMBP_IDX_LOWER_DATA = 6'h01;
   localparam logic [5:0] BMBP_IDX_UPPER_DIR = 6'h02;
   localparam logic [5:0] BMBP_IDX_LOWER_DIR = 6'h03;
   localparam logic [5:0] BMBP_IDX_RSVD_LAST = 6'h07;
   localparam logic [5:0] BMBP_IDX_MODE = 6'h10;
   localparam int BMBP_ADDR_LSB = 2;
   localparam int BMBP_ADDR_W = 8;

   // ------------------------------------------------------------
   // field layout and reset values
   // ------------------------------------------------------------
   localparam int BMBP_PORT_W = 8;
   localparam int BMBP_MODE_EXP_BIT = 0;
   localparam logic [7:0] BMBP_DATA_RST = 8'h00;
   localparam logic [7:0] BMBP_DIR_RST = 8'h00;
   localparam logic [7:0] BMBP_ALL_OUT = 8'hFF;
   localparam logic [31:0] BMBP_RDATA_RST = 32'h0000_0000;

   // ------------------------------------------------------------
   // operating modes
   // ------------------------------------------------------------
   typedef enum logic {
      BMBP_SINGLE_CHIP = 1'b0,
      BMBP_EXPANDED = 1'b1
   } bmbp_mode_type;

   // ------------------------------------------------------------
   // apb slave answer sequence
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      BMBP_IDLE = 2'b00,
      BMBP_ANSWER = 2'b01
   } bmbp_apb_type;

endpackage

// file: core/bmbp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bmbp_sync
   import bmbp_pkg::*;
#(
   parameter int WIDTH = BMBP_PORT_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   // ------------------------------------------------------------
   // three-stage catch, change accepted when stages two and three agree
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         logic s1_r;
         logic s2_r;
         logic s3_r;
         logic out_r;
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
               s3_r <= 1'b0;
               out_r <= 1'b0;
            end else if (ce) begin
               s1_r <= din[gi];
               s2_r <= s1_r;
               s3_r <= s2_r;
               if (s2_r == s3_r) begin
                  out_r <= s3_r;
               end
            end
         end
         assign dout[gi] = out_r;
      end
   endgenerate

endmodule
`default_nettype wire

// file: core/bmbp_top.sv
// Summary of operation
// - in external bus modes the upper port pins carry address A15..A8 and data D15..D8 in bit order.
// - in external bus modes the lower port pins carry address A7..A0 and data D7..D0 in bit order.
// - when the upper port carries no external address its pins are general-purpose I/O.
// - when the lower port carries no external address its pins are general-purpose I/O.
// - each upper pin takes its direction and its read source from its upper direction bit.
// - each lower pin takes its direction and its read source from its lower direction bit.
// - in expanded modes both data registers leave the map and their accesses are echoed outward.
// - while mapped both data registers read and write at any time and reset to zero.
// - a direction bit of one makes the pin an output and zero makes it a high-impedance input.
// - a data read returns the filtered pin for input bits and the stored bit for output bits.
// - both direction registers reset to zero so they never override the bus three-state control.
`timescale 1ns/1ps
`default_nettype none
module bmbp_top
   import bmbp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [BMBP_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic ext_addr_phase,
   input wire logic ext_drive_data,
   input wire logic [15:0] ext_addr,
   input wire logic [15:0] ext_data,
   output logic echo_req,
   output logic echo_write,
   output logic [5:0] echo_index,
   output logic [7:0] echo_wdata,
   input wire logic [7:0] upper_port_pin_in,
   output logic [7:0] upper_port_pin_out,
   output logic [7:0] upper_port_pin_oe,
   input wire logic [7:0] lower_port_pin_in,
   output logic [7:0] lower_port_pin_out,
   output logic [7:0] lower_port_pin_oe,
   output logic expanded_mode
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [7:0] upper_port_data_r;
   logic [7:0] lower_port_data_r;
   logic [7:0] upper_port_direction_r;
   logic [7:0] lower_port_direction_r;
   bmbp_mode_type mode_r;
   bmbp_apb_type apb_r;
   logic pready_r;
   logic [31:0] prdata_r;
   logic pslverr_r;
   logic echo_req_r;
   logic echo_write_r;
   logic [5:0] echo_index_r;
   logic [7:0] echo_wdata_r;
   logic [7:0] up_out_r;
   logic [7:0] up_oe_r;
   logic [7:0] lo_out_r;
   logic [7:0] lo_oe_r;
   logic [7:0] upper_pin_f;
   logic [7:0] lower_pin_f;
   logic [5:0] idx;
   logic access;
   logic commit;
   logic exp_mode;
   logic [31:0] rdata_nxt;
   logic err_nxt;
   logic [7:0] up_out_nxt;
   logic [7:0] up_oe_nxt;
   logic [7:0] lo_out_nxt;
   logic [7:0] lo_oe_nxt;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] read_mix(input logic [7:0] dir, input logic [7:0] data,
                                           input logic [7:0] pins);
      read_mix = (dir & data) | (~dir & pins);
   endfunction

   function automatic logic port_reg(input logic [5:0] i);
      port_reg = (i <= BMBP_IDX_LOWER_DIR);
   endfunction

   // ------------------------------------------------------------
   // pin input synchroniser
   // ------------------------------------------------------------
   bmbp_sync #(.WIDTH(16)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .din({upper_port_pin_in, lower_port_pin_in}),
      .dout({upper_pin_f, lower_pin_f})
   );

   assign idx = paddr[BMBP_ADDR_LSB +: 6];
   assign exp_mode = (mode_r == BMBP_EXPANDED);
   assign access = psel && penable;
   assign commit = access && pready_r;

   // ------------------------------------------------------------
   // read decode
   // ------------------------------------------------------------
   always_comb begin
      rdata_nxt = BMBP_RDATA_RST;
      err_nxt = 1'b0;
      if (port_reg(idx) && exp_mode) begin
         rdata_nxt = BMBP_RDATA_RST;
      end else begin
         case (idx)
            BMBP_IDX_UPPER_DATA: begin
               rdata_nxt[7:0] = read_mix(upper_port_direction_r, upper_port_data_r, upper_pin_f);
            end
            BMBP_IDX_LOWER_DATA: begin
               rdata_nxt[7:0] = read_mix(lower_port_direction_r, lower_port_data_r, lower_pin_f);
            end
            BMBP_IDX_UPPER_DIR: begin
               rdata_nxt[7:0] = upper_port_direction_r;
            end
            BMBP_IDX_LOWER_DIR: begin
               rdata_nxt[7:0] = lower_port_direction_r;
            end
            BMBP_IDX_MODE: begin
               rdata_nxt[BMBP_MODE_EXP_BIT] = exp_mode;
            end
            default: begin
               // reserved words read zero without error, anything past them is unmapped
               err_nxt = (idx > BMBP_IDX_RSVD_LAST);
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // apb answer: one wait state, read data captured on the edge that raises pready, writes taken on the completing edge
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         apb_r <= BMBP_IDLE;
         pready_r <= 1'b0;
         prdata_r <= BMBP_RDATA_RST;
         pslverr_r <= 1'b0;
      end else if (ce) begin
         case (apb_r)
            BMBP_IDLE: begin
               if (access) begin
                  apb_r <= BMBP_ANSWER;
                  pready_r <= 1'b1;
                  prdata_r <= pwrite ? BMBP_RDATA_RST : rdata_nxt;
                  pslverr_r <= err_nxt;
               end
            end
            BMBP_ANSWER: begin
               apb_r <= BMBP_IDLE;
               pready_r <= 1'b0;
               pslverr_r <= 1'b0;
            end
            default: begin
               apb_r <= BMBP_IDLE;
               pready_r <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         upper_port_data_r <= BMBP_DATA_RST;
         lower_port_data_r <= BMBP_DATA_RST;
         upper_port_direction_r <= BMBP_DIR_RST;
         lower_port_direction_r <= BMBP_DIR_RST;
         mode_r <= BMBP_SINGLE_CHIP;
      end else if (ce && commit && pwrite) begin
         if (!exp_mode) begin
            case (idx)
               BMBP_IDX_UPPER_DATA: upper_port_data_r <= pwdata[7:0];
               BMBP_IDX_LOWER_DATA: lower_port_data_r <= pwdata[7:0];
               BMBP_IDX_UPPER_DIR: upper_port_direction_r <= pwdata[7:0];
               BMBP_IDX_LOWER_DIR: lower_port_direction_r <= pwdata[7:0];
               default: begin
               end
            endcase
         end
         if (idx == BMBP_IDX_MODE) begin
            mode_r <= bmbp_mode_type'(pwdata[BMBP_MODE_EXP_BIT]);
         end
      end
   end

   // ------------------------------------------------------------
   // echo of unmapped port accesses onto the external bus
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         echo_req_r <= 1'b0;
         echo_write_r <= 1'b0;
         echo_index_r <= 6'h00;
         echo_wdata_r <= 8'h00;
      end else if (ce) begin
         echo_req_r <= commit && exp_mode && port_reg(idx);
         if (commit && exp_mode && port_reg(idx)) begin
            echo_write_r <= pwrite;
            echo_index_r <= idx;
            echo_wdata_r <= pwdata[7:0];
         end
      end
   end

   // ------------------------------------------------------------
   // pin drive
   // ------------------------------------------------------------
   always_comb begin
      if (exp_mode) begin
         // address phase drives the address, data phase drives only when writing outward
         up_out_nxt = ext_addr_phase ? ext_addr[15:8] : ext_data[15:8];
         lo_out_nxt = ext_addr_phase ? ext_addr[7:0] : ext_data[7:0];
         up_oe_nxt = (ext_addr_phase || ext_drive_data) ? BMBP_ALL_OUT : BMBP_DIR_RST;
         lo_oe_nxt = (ext_addr_phase || ext_drive_data) ? BMBP_ALL_OUT : BMBP_DIR_RST;
      end else begin
         up_out_nxt = upper_port_data_r;
         lo_out_nxt = lower_port_data_r;
         up_oe_nxt = upper_port_direction_r;
         lo_oe_nxt = lower_port_direction_r;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         up_out_r <= BMBP_DATA_RST;
         lo_out_r <= BMBP_DATA_RST;
         up_oe_r <= BMBP_DIR_RST;
         lo_oe_r <= BMBP_DIR_RST;
      end else if (ce) begin
         up_out_r <= up_out_nxt;
         lo_out_r <= lo_out_nxt;
         up_oe_r <= up_oe_nxt;
         lo_oe_r <= lo_oe_nxt;
      end
   end

   // the direction register applies one edge late, hence software waits before reading pins
   assign pready = pready_r;
   assign prdata = prdata_r;
   assign pslverr = pslverr_r;
   assign echo_req = echo_req_r;
   assign echo_write = echo_write_r;
   assign echo_index = echo_index_r;
   assign echo_wdata = echo_wdata_r;
   assign upper_port_pin_out = up_out_r;
   assign upper_port_pin_oe = up_oe_r;
   assign lower_port_pin_out = lo_out_r;
   assign lower_port_pin_oe = lo_oe_r;
   assign expanded_mode = mode_r;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence apb_setup_s;
      ce && psel && penable && !pready_r;
   endsequence

   sequence apb_done_s(logic [5:0] i, logic wr);
      ce && commit && (idx == i) && (pwrite == wr);
   endsequence

   upper_addr_drive_a: assert property (ce && exp_mode && ext_addr_phase |=>
      upper_port_pin_oe == BMBP_ALL_OUT && upper_port_pin_out == $past(ext_addr[15:8]))
      else $error("upper port not carrying address high byte");

   lower_addr_drive_a: assert property (ce && exp_mode && ext_addr_phase |=>
      lower_port_pin_oe == BMBP_ALL_OUT && lower_port_pin_out == $past(ext_addr[7:0]))
      else $error("lower port not carrying address low byte");

   upper_gpio_pins_a: assert property (ce && !exp_mode |=>
      upper_port_pin_oe == $past(upper_port_direction_r) && upper_port_pin_out == $past(upper_port_data_r))
      else $error("upper pins do not follow direction and data");

   lower_gpio_pins_a: assert property (ce && !exp_mode |=>
      lower_port_pin_oe == $past(lower_port_direction_r) && lower_port_pin_out == $past(lower_port_data_r))
      else $error("lower pins do not follow direction and data");

   unmapped_echo_a: assert property (apb_done_s(BMBP_IDX_UPPER_DATA, 1'b1) and exp_mode |=>
      echo_req && upper_port_data_r == $past(upper_port_data_r))
      else $error("expanded-mode access not echoed or register changed");

   data_write_a: assert property (apb_done_s(BMBP_IDX_LOWER_DATA, 1'b1) and !exp_mode |=>
      lower_port_data_r == $past(pwdata[7:0]))
      else $error("lower data write lost");

   read_source_a: assert property (apb_setup_s and !pwrite && !exp_mode && idx == BMBP_IDX_UPPER_DATA |=>
      prdata[7:0] == $past(read_mix(upper_port_direction_r, upper_port_data_r, upper_pin_f)))
      else $error("upper data read mixes wrong sources");

   answer_timing_a: assert property (apb_setup_s |=> pready ##1 (!ce || !pready))
      else $error("apb answer not one wait state wide");

endmodule
`default_nettype wire

// file: test/bmbp_ext_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// far side of the port pins: memory or peripherals on the bus
// ------------------------------------------------------------
module bmbp_ext_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] upper_port_pin_out,
   input wire logic [7:0] upper_port_pin_oe,
   input wire logic [7:0] lower_port_pin_out,
   input wire logic [7:0] lower_port_pin_oe,
   input wire logic [15:0] far_drive,
   output logic [7:0] upper_port_pin_in,
   output logic [7:0] lower_port_pin_in,
   output logic [15:0] seen_bus_r
);
   // the device wins on driven bits, the far side drives the released ones
   assign upper_port_pin_in = (upper_port_pin_oe & upper_port_pin_out) | (~upper_port_pin_oe & far_drive[15:8]);
   assign lower_port_pin_in = (lower_port_pin_oe & lower_port_pin_out) | (~lower_port_pin_oe & far_drive[7:0]);

   // latches the word only while all sixteen lines are driven by the device
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seen_bus_r <= 16'h0000;
      end else if (&{upper_port_pin_oe, lower_port_pin_oe}) begin
         seen_bus_r <= {upper_port_pin_in, lower_port_pin_in};
      end
   end
endmodule
`default_nettype wire

// file: test/tb_bus_multiplexed_byte_ports.sv
`timescale 1ns/1ps
`default_nettype none
module tb_bus_multiplexed_byte_ports;
   import bmbp_pkg::*;
   logic clk, rst_n, ce, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic ext_addr_phase, ext_drive_data, echo_req, echo_write, expanded_mode;
   logic [15:0] ext_addr, ext_data, far_drive, seen_bus;
   logic [5:0] echo_index;
   logic [7:0] echo_wdata, up_in, up_out, up_oe, lo_in, lo_out, lo_oe;
   int miscompares = 0;
   int compares = 0;
   int cycles = 0;

   bmbp_top dut_u (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .ext_addr_phase(ext_addr_phase), .ext_drive_data(ext_drive_data), .ext_addr(ext_addr),
      .ext_data(ext_data), .echo_req(echo_req), .echo_write(echo_write), .echo_index(echo_index),
      .echo_wdata(echo_wdata), .upper_port_pin_in(up_in), .upper_port_pin_out(up_out),
      .upper_port_pin_oe(up_oe), .lower_port_pin_in(lo_in), .lower_port_pin_out(lo_out),
      .lower_port_pin_oe(lo_oe), .expanded_mode(expanded_mode));

   bmbp_ext_model far_u (.clk(clk), .rst_n(rst_n), .upper_port_pin_out(up_out), .upper_port_pin_oe(up_oe),
      .lower_port_pin_out(lo_out), .lower_port_pin_oe(lo_oe), .far_drive(far_drive),
      .upper_port_pin_in(up_in), .lower_port_pin_in(lo_in), .seen_bus_r(seen_bus));

   always #5 clk = ~clk;

   // ------------------------------------------------------------
   // reporting
   // ------------------------------------------------------------
   task automatic print_verdict();
      if (miscompares == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   // the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares++;
         print_verdict();
      end
   end

   // ------------------------------------------------------------
   // apb master: starts one edge later so a strobe is never set twice per step
   // ------------------------------------------------------------
   task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // no limit of its own: only the bench timeout ends a hung wait
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] idx, input logic [7:0] v);
      logic [31:0] d;
      logic e;
      apb(1'b1, idx, {24'h000000, v}, d, e);
   endtask

   task automatic rchk(input string name, input logic [5:0] idx, input logic [7:0] exp, input logic exp_err);
      logic [31:0] d;
      logic e;
      apb(1'b0, idx, 32'h0000_0000, d, e);
      chk(name, {24'h000000, exp}, d);
      chk({name, " err"}, {31'h0, exp_err}, {31'h0, e});
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      ce = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {ext_addr_phase, ext_drive_data, ext_addr, ext_data} = '0;
      far_drive = 16'h0000;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk("oe after reset", 16'h0000, {up_oe, lo_oe});
      rchk("upper data reset", BMBP_IDX_UPPER_DATA, 8'h00, 1'b0);
      rchk("lower data reset", BMBP_IDX_LOWER_DATA, 8'h00, 1'b0);
      rchk("upper dir reset", BMBP_IDX_UPPER_DIR, 8'h00, 1'b0);
      rchk("lower dir reset", BMBP_IDX_LOWER_DIR, 8'h00, 1'b0);
      far_drive <= 16'h3CC3;
      wr(BMBP_IDX_UPPER_DIR, 8'hF0);
      wr(BMBP_IDX_UPPER_DATA, 8'hA5);
      wr(BMBP_IDX_LOWER_DIR, 8'h0F);
      wr(BMBP_IDX_LOWER_DATA, 8'h5A);
      settle(5);
      chk("upper oe", 8'hF0, up_oe);
      chk("upper out", 8'hA5, up_out);
      chk("lower oe", 8'h0F, lo_oe);
      chk("lower out", 8'h5A, lo_out);
      rchk("upper mixed read", BMBP_IDX_UPPER_DATA, 8'hAC, 1'b0);
      rchk("lower mixed read", BMBP_IDX_LOWER_DATA, 8'hCA, 1'b0);
      rchk("upper dir", BMBP_IDX_UPPER_DIR, 8'hF0, 1'b0);
      wr(BMBP_IDX_UPPER_DIR, 8'h00);
      settle(5);
      rchk("upper input read", BMBP_IDX_UPPER_DATA, 8'h3C, 1'b0);
      wr(BMBP_IDX_UPPER_DIR, 8'hFF);
      settle(2);
      rchk("upper output read", BMBP_IDX_UPPER_DATA, 8'hA5, 1'b0);
      wr(6'h04, 8'hFF);
      rchk("reserved", 6'h04, 8'h00, 1'b0);
      rchk("unmapped", 6'h20, 8'h00, 1'b1);
      // expanded mode: data registers leave the map and are echoed
      wr(BMBP_IDX_MODE, 8'h01);
      #1;
      chk("expanded", 1'b1, expanded_mode);
      wr(BMBP_IDX_UPPER_DATA, 8'h77);
      #1;
      chk("echo write", {1'b1, 1'b1, 6'h00, 8'h77}, {echo_req, echo_write, echo_index, echo_wdata});
      rchk("unmapped lower", BMBP_IDX_LOWER_DATA, 8'h00, 1'b0);
      #1;
      chk("echo read", {1'b1, 1'b0, 6'h01}, {echo_req, echo_write, echo_index});
      @(posedge clk);
      ext_addr_phase <= 1'b1;
      ext_addr <= 16'h1234;
      @(posedge clk);
      ext_addr_phase <= 1'b0;
      ext_drive_data <= 1'b1;
      ext_data <= 16'hABCD;
      #1;
      chk("addr oe", 16'hFFFF, {up_oe, lo_oe});
      chk("addr out", 16'h1234, {up_out, lo_out});
      @(posedge clk);
      ext_drive_data <= 1'b0;
      #1;
      chk("data out", 16'hABCD, {up_out, lo_out});
      chk("far addr", 16'h1234, seen_bus);
      settle(1);
      chk("bus released", 16'h0000, {up_oe, lo_oe});
      chk("far data", 16'hABCD, seen_bus);
      // clock enable low must freeze the pins although an address phase is asked for
      @(posedge clk);
      ce <= 1'b0;
      ext_addr_phase <= 1'b1;
      ext_addr <= 16'h5A5A;
      settle(3);
      chk("frozen oe", 16'h0000, {up_oe, lo_oe});
      @(posedge clk);
      ce <= 1'b1;
      settle(1);
      chk("resumed addr", 16'h5A5A, {up_out, lo_out});
      @(posedge clk);
      ext_addr_phase <= 1'b0;
      wr(BMBP_IDX_MODE, 8'h00);
      settle(5);
      chk("gpio oe back", 16'hFF0F, {up_oe, lo_oe});
      rchk("upper kept", BMBP_IDX_UPPER_DATA, 8'hA5, 1'b0);
      print_verdict();
   end
endmodule
`default_nettype wire
